// >>> rtl/mhls_monitor.sv
// Monitor command interpreter with entry security check and baud choice
`timescale 1ns/1ns
module mhls_monitor
	import mhls_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        warmReset,
	input  wire logic        baud_select_strap,
	input  wire logic        laterRevision,
	input  wire logic        pllDrivesClock,
	input  wire logic [3:0]  pll_multiplier_upper_bits,
	input  wire logic [15:0] indexAddr,
	input  wire logic [15:0] stackPointer,
	input  wire logic        flashExecAttempt,
	output logic             memRdReq,
	output logic [15:0]      memAddr,
	input  wire logic [7:0]  memRdData,
	output logic             indexAdvance,
	output logic             return_from_interrupt,
	output logic             illegalAddrReset,
	output logic             flashReadEnable,
	output logic             securityBypassed,
	output logic             monitorReady,
	input  wire logic        monitor_serial_pin_in,
	output logic             monitor_serial_pin_out,
	output logic             monitor_serial_pin_oe
);

	typedef enum logic [3:0] {
		M_SEC_RX, M_SEC_CMP, M_SEC_WAIT, M_BREAK, M_BREAK_WAIT, M_CMD,
		M_ECHO_WAIT, M_FETCH, M_FETCH_DATA, M_SEND, M_SEND_WAIT
	} mhls_mode_e;

	typedef struct packed {
		mhls_mode_e  mode;
		logic [2:0]  count;
		logic [7:0]  opcode;
		logic [15:0] dataBuf;
		logic        mismatch;
		logic        bypassed;
		logic        failed;
		logic        strapPending;
		logic        strapHigh;
		mhls_tx_s    tx;
		logic        memReq;
		logic [15:0] memAddr;
		logic        runPulse;
		logic        illegalPulse;
		logic        indexStep;
	} mhls_mon_s;

	mhls_mon_s   st;
	mhls_mon_s   next_st;
	logic [10:0] bitPeriod;
	logic        txBusy;
	mhls_rx_s    rx;

	////////////////////////////////////////////////////////////////////////////
	// Bit period in clocks from strap, revision and PLL multiplier
	function automatic logic [10:0] bit_period(input logic strap, input logic late,
		input logic pll, input logic [3:0] mult);
		logic [10:0] p;
		p = DIV_SLOW;
		if (pll)
		begin
			unique case (mult)
				4'h2:    p = DIV_SLOW / 11'h002;
				4'h3:    p = DIV_SLOW / 11'h003;
				4'h4:    p = DIV_SLOW / 11'h004;
				4'h5:    p = DIV_SLOW / 11'h005;
				4'h6:    p = DIV_SLOW / 11'h006;
				default: p = DIV_SLOW; // Outside 1..6 falls back to N=1
			endcase
		end
		else if (late)
			p = strap ? DIV_LATE_SLOW : DIV_LATE_FAST;
		else
			p = strap ? DIV_SLOW : DIV_FAST;
		return p;
	endfunction

	assign bitPeriod = bit_period(st.strapHigh, laterRevision, pllDrivesClock,
		pll_multiplier_upper_bits);

	////////////////////////////////////////////////////////////////////////////
	// Serial engine on the monitor pin
	mhls_serial u_serial (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.bitPeriod (bitPeriod),
		.txReq     (st.tx),
		.txBusy    (txBusy),
		.rxOut     (rx),
		.serialIn  (monitor_serial_pin_in),
		.serialOut (monitor_serial_pin_out),
		.serialOe  (monitor_serial_pin_oe)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer; pulses clear every cycle unless set below
	always_comb
	begin
		next_st              = st;
		next_st.tx.start     = 1'b0;
		next_st.tx.brk       = 1'b0;
		next_st.memReq       = 1'b0;
		next_st.runPulse     = 1'b0;
		next_st.illegalPulse = 1'b0;
		next_st.indexStep    = 1'b0;
		// Strap is caught once after release of power-on reset and again after each warm reset
		if (st.strapPending)
		begin
			next_st.strapHigh    = baud_select_strap;
			next_st.strapPending = 1'b0;
		end
		unique case (st.mode)
			M_SEC_RX:
			begin
				// Nothing else happens until the next of the eight bytes arrives
				if (rx.valid)
				begin
					next_st.dataBuf[7:0] = rx.data;
					next_st.memReq       = 1'b1;
					next_st.memAddr      = SEC_BASE_ADDR + 16'(st.count);
					next_st.mode         = M_SEC_CMP;
				end
			end
			M_SEC_CMP:
			begin
				if (memRdData != st.dataBuf[7:0])
					next_st.mismatch = 1'b1;
				next_st.tx.start = 1'b1;
				next_st.tx.data  = st.dataBuf[7:0];
				next_st.mode     = M_SEC_WAIT;
			end
			M_SEC_WAIT:
			begin
				if (!txBusy)
				begin
					next_st.count = st.count + 3'h1;
					next_st.mode  = (st.count == SEC_LAST_INDEX) ? M_BREAK : M_SEC_RX;
				end
			end
			M_BREAK:
			begin
				// An earlier bypass survives any byte values
				if (!st.bypassed)
				begin
					next_st.bypassed = !st.mismatch;
					next_st.failed   = st.mismatch;
				end
				next_st.tx.brk = 1'b1;
				next_st.mode   = M_BREAK_WAIT;
			end
			M_BREAK_WAIT:
				if (!txBusy)
					next_st.mode = M_CMD;
			M_CMD:
			begin
				// Every opcode is echoed before it is acted on
				if (rx.valid)
				begin
					next_st.opcode   = rx.data;
					next_st.tx.start = 1'b1;
					next_st.tx.data  = rx.data;
					next_st.mode     = M_ECHO_WAIT;
				end
			end
			M_ECHO_WAIT:
			begin
				if (!txBusy)
				begin
					next_st.count = 3'h0;
					next_st.mode  = M_CMD; // Unknown opcodes are only echoed
					if (st.opcode == OP_READ_SP)
					begin
						next_st.dataBuf = stackPointer;
						next_st.mode    = M_SEND;
					end
					else if (st.opcode == OP_INDEXED_READ)
						next_st.mode = M_FETCH;
					else if (st.opcode == OP_RUN_USER)
						next_st.runPulse = 1'b1;
				end
			end
			M_FETCH:
			begin
				next_st.memReq  = 1'b1;
				next_st.memAddr = indexAddr + 16'h0001 + 16'(st.count);
				next_st.mode    = M_FETCH_DATA;
			end
			M_FETCH_DATA:
			begin
				next_st.dataBuf = {st.dataBuf[7:0], memRdData};
				next_st.count   = st.count + 3'h1;
				next_st.mode    = M_FETCH;
				if (st.count == 3'h1)
				begin
					next_st.count     = 3'h0;
					next_st.indexStep = 1'b1;
					next_st.mode      = M_SEND;
				end
			end
			M_SEND:
			begin
				next_st.tx.start = 1'b1;
				next_st.tx.data  = st.dataBuf[15:8];
				next_st.dataBuf  = {st.dataBuf[7:0], 8'h00};
				next_st.mode     = M_SEND_WAIT;
			end
			M_SEND_WAIT:
			begin
				if (!txBusy)
				begin
					next_st.count = st.count + 3'h1;
					next_st.mode  = (st.count == 3'h1) ? M_CMD : M_SEND;
				end
			end
		endcase
		// Locked part: flash execution trips an illegal address reset
		if (flashExecAttempt && !st.bypassed)
			next_st.illegalPulse = 1'b1;
		// Warm reset restarts entry, keeps bypass; a failed part loops
		if (warmReset)
		begin
			next_st.mode         = M_SEC_RX;
			next_st.count        = 3'h0;
			next_st.mismatch     = 1'b0;
			next_st.strapPending = 1'b1;
			next_st.tx.start     = 1'b0;
			next_st.tx.brk       = 1'b0;
			next_st.memReq       = 1'b0;
			next_st.runPulse     = 1'b0;
			next_st.indexStep    = 1'b0;
			// Set wins, so a same-cycle locked execution trap is not lost
			if (st.failed)
				next_st.illegalPulse = 1'b1;
		end
	end

	// Power-on reset is the only thing that clears the bypass state
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st              <= '0;
			st.mode         <= M_SEC_RX;
			st.strapPending <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign memRdReq              = st.memReq;
	assign memAddr               = st.memAddr;
	assign indexAdvance          = st.indexStep;
	assign return_from_interrupt = st.runPulse;
	assign illegalAddrReset      = st.illegalPulse;
	// Security fetches always see flash; others only once bypassed
	assign flashReadEnable       = st.bypassed || st.mode == M_SEC_CMP;
	assign securityBypassed      = st.bypassed;
	assign monitorReady          = st.mode == M_CMD;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence s_warm_failed;
		warmReset && st.failed;
	endsequence
	sequence s_sp_echo_done;
		st.mode == M_ECHO_WAIT && !txBusy && st.opcode == OP_READ_SP;
	endsequence

	a_break_after_eight: assert property (st.tx.brk |-> $past(st.count) == 3'h0
		&& $past(st.mode) == M_BREAK) else $error("Break sent early");
	a_bypass_holds: assert property (st.bypassed && !warmReset |=> st.bypassed)
		else $error("Bypass lost");
	a_bypass_warm: assert property (warmReset && st.bypassed |=> ##[1:2] st.bypassed)
		else $error("Bypass lost on warm reset");
	a_exec_locked: assert property (flashExecAttempt && !st.bypassed |=> illegalAddrReset)
		else $error("Locked execution not trapped");
	a_warm_loop: assert property (s_warm_failed |=> illegalAddrReset && st.mode == M_SEC_RX)
		else $error("Failed part warm reset not trapped");
	a_sp_high_first: assert property ((s_sp_echo_done and !warmReset) |=> ##1
		st.tx.start && st.tx.data == $past(stackPointer[15:8], 2))
		else $error("Stack pointer order wrong");
	a_run_echo: assert property (return_from_interrupt |-> st.opcode == OP_RUN_USER)
		else $error("Run pulse without run opcode");
	a_sec_addr: assert property (memRdReq && st.mode == M_SEC_CMP |->
		memAddr == SEC_BASE_ADDR + 16'(st.count)) else $error("Bad key address");
	a_fetch_addr: assert property (memRdReq && st.mode == M_FETCH_DATA |->
		memAddr == $past(indexAddr) + 16'h0001 + 16'(st.count))
		else $error("Bad indexed address");
	a_baud_strap: assert property (!pllDrivesClock && !laterRevision |->
		bitPeriod == (st.strapHigh ? DIV_SLOW : DIV_FAST)) else $error("Bad baud");
	a_no_cmd_locked: assert property (st.mode == M_SEC_RX |-> !st.tx.start
		&& !return_from_interrupt) else $error("Activity before entry");

endmodule

// >>> rtl/mhls_pkg.sv
// Constants and types shared by the monitor link blocks
package mhls_pkg;

	// Command opcodes
	localparam logic [7:0] OP_INDEXED_READ = 8'h1A;
	localparam logic [7:0] OP_READ_SP      = 8'h0C;
	localparam logic [7:0] OP_RUN_USER     = 8'h28;

	// Security block location and count
	localparam logic [15:0] SEC_BASE_ADDR  = 16'hFFF6;
	localparam logic [2:0]  SEC_LAST_INDEX = 3'h7;

	// Read value on a locked flash access
	localparam logic [7:0] LOCKED_READ_VALUE = 8'hFF;

	// Baud timing: block clock stands in for the crystal
	localparam int BASE_XTAL_HZ   = 4915200;
	localparam int BASE_BAUD_SLOW = 4800;
	localparam int BASE_BAUD_FAST = 9600;
	localparam int LATE_XTAL_HZ   = 4000000;
	localparam int LATE_BAUD_SLOW_X100 = 362319;
	localparam int DIV_SLOW_I      = BASE_XTAL_HZ / BASE_BAUD_SLOW;
	localparam int DIV_FAST_I      = BASE_XTAL_HZ / BASE_BAUD_FAST;
	// Rounded to nearest so the low-strap period is exactly half of it
	localparam int DIV_LATE_SLOW_I =
		(LATE_XTAL_HZ * 100 + LATE_BAUD_SLOW_X100 / 2) / LATE_BAUD_SLOW_X100;
	localparam logic [10:0] DIV_SLOW      = 11'(DIV_SLOW_I);
	localparam logic [10:0] DIV_FAST      = 11'(DIV_FAST_I);
	localparam logic [10:0] DIV_LATE_SLOW = 11'(DIV_LATE_SLOW_I);
	localparam logic [10:0] DIV_LATE_FAST = 11'(DIV_LATE_SLOW_I / 2);

	// Frame layout: start, eight data, stop
	localparam logic [3:0] FRAME_LAST_BIT = 4'h9;

	// Transmit request to the serial engine
	typedef struct packed {
		logic       start;
		logic       brk;
		logic [7:0] data;
	} mhls_tx_s;

	// Received byte from the serial engine
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} mhls_rx_s;

endpackage

// >>> rtl/mhls_serial.sv
// Half-duplex single-wire serial engine for the monitor pin
`timescale 1ns/1ns
module mhls_serial
	import mhls_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic [10:0] bitPeriod,
	input  wire mhls_tx_s    txReq,
	output logic             txBusy,
	output mhls_rx_s         rxOut,
	input  wire logic        serialIn,
	output logic             serialOut,
	output logic             serialOe
);

	typedef struct packed {
		logic        txActive;
		logic [10:0] txTimer;
		logic [3:0]  txBit;
		logic [9:0]  txShift;
		logic        rxActive;
		logic [10:0] rxTimer;
		logic [3:0]  rxBit;
		logic [7:0]  rxShift;
		mhls_rx_s    rx;
		logic        pinLow;
	} mhls_ser_s;

	mhls_ser_s st;
	mhls_ser_s next_st;

	////////////////////////////////////////////////////////////////////////////
	// Next state; receive is held off while sending, since the pin hears itself
	always_comb
	begin
		next_st          = st;
		next_st.rx.valid = 1'b0;
		// Transmit side, one bit per period, LSB first after start
		if (!st.txActive && (txReq.start || txReq.brk))
		begin
			next_st.txActive = 1'b1;
			next_st.txTimer  = bitPeriod;
			next_st.txBit    = 4'h0;
			next_st.txShift  = txReq.brk ? 10'h000 : {1'b1, txReq.data, 1'b0};
		end
		else if (st.txActive)
		begin
			if (st.txTimer > 11'h001)
				next_st.txTimer = st.txTimer - 11'h001;
			else if (st.txBit == FRAME_LAST_BIT)
				next_st.txActive = 1'b0;
			else
			begin
				next_st.txTimer = bitPeriod;
				next_st.txBit   = st.txBit + 4'h1;
				next_st.txShift = {1'b1, st.txShift[9:1]};
			end
		end
		next_st.pinLow = next_st.txActive && !next_st.txShift[0];
		// Receive side, sampled mid-bit
		if (!st.rxActive && !st.txActive && !serialIn)
		begin
			next_st.rxActive = 1'b1;
			next_st.rxTimer  = {1'b0, bitPeriod[10:1]};
			next_st.rxBit    = 4'h0;
		end
		else if (st.rxActive)
		begin
			if (st.rxTimer > 11'h001)
				next_st.rxTimer = st.rxTimer - 11'h001;
			else
			begin
				next_st.rxTimer = bitPeriod;
				next_st.rxBit   = st.rxBit + 4'h1;
				if (st.rxBit == 4'h0 && serialIn)
					next_st.rxActive = 1'b0; // Glitch, not a start bit
				else if (st.rxBit == FRAME_LAST_BIT)
				begin
					next_st.rxActive = 1'b0;
					next_st.rx.valid = serialIn; // Bad stop bit drops the byte
					next_st.rx.data  = st.rxShift;
				end
				else if (st.rxBit != 4'h0)
					next_st.rxShift = {serialIn, st.rxShift[7:1]};
			end
		end
	end

	// State register
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			st <= '0;
		else
			st <= next_st;
	end

	// A request being taken this cycle already counts as busy
	assign txBusy    = st.txActive || txReq.start || txReq.brk;
	assign rxOut     = st.rx;
	assign serialOut = 1'b0; // Open drain: only ever pulls low
	assign serialOe  = st.pinLow;

endmodule

// >>> testbench/mhls_host.sv
// Host computer model for the single-wire monitor line
`timescale 1ns/1ns
module mhls_host
(
	input  wire logic mclk,
	input  wire logic line,
	output logic      pullLow
);
	int bitPeriod = 170;

	// Released line floats high through the pull-up
	initial pullLow = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// One frame out; stop bit cut to half so the echo start is not missed
	task automatic send_byte(input logic [7:0] b);
		int i;
		@(negedge mclk);
		pullLow = 1'b1; // Start bit
		repeat (bitPeriod) @(negedge mclk);
		for (i = 0; i < 8; i++)
		begin
			pullLow = ~b[i]; // LSB first
			repeat (bitPeriod) @(negedge mclk);
		end
		pullLow = 1'b0;
		repeat (bitPeriod / 2) @(negedge mclk);
	endtask

	// One frame in; waits out the stop bit so the next send is not refused
	task automatic recv_byte(output logic [7:0] b, output logic stopBit, output logic ok);
		int i;
		ok = 1'b0;
		b = 8'h00;
		stopBit = 1'b0;
		for (i = 0; i < 4 * bitPeriod && !ok; i++)
		begin
			@(negedge mclk);
			ok = (line === 1'b0);
		end
		if (ok)
		begin
			repeat (bitPeriod / 2) @(negedge mclk);
			for (i = 0; i < 8; i++)
			begin
				repeat (bitPeriod) @(negedge mclk);
				b[i] = line;
			end
			repeat (bitPeriod) @(negedge mclk);
			stopBit = line;
			repeat (bitPeriod / 2 + 4) @(negedge mclk);
		end
	endtask
endmodule

// >>> testbench/mhls_monitor_test.sv
// Self-checking bench for the monitor command interpreter
`timescale 1ns/1ns
module mhls_monitor_test
	import mhls_pkg::*;
;
	logic        mclk = 1'b0;
	logic        rst_b, warmReset, flashExecAttempt, hostPull, line;
	logic [3:0]  mult;
	logic [15:0] indexAddr, stackPointer, memAddr;
	logic [7:0]  memRdData;
	logic        memRdReq, indexAdvance, rfiPulse, illegalAddrReset;
	logic        baudStrap, laterRevision, pllDrivesClock;
	logic        flashReadEnable, securityBypassed, monitorReady, pinOut, pinOe;
	int          numErrors = 0;
	int          checksDone = 0;
	int          rfiCount = 0;
	int          iarCount = 0;
	int          advCount = 0;
	logic [7:0]  key [8] = '{8'h5A, 8'hC3, 8'h01, 8'h80, 8'h7E, 8'h00, 8'hFF, 8'h96};

	always #50 mclk = ~mclk;

	// Open-drain wire: either party pulling wins
	assign line = ~((pinOe & ~pinOut) | hostPull);

	mhls_monitor i_dut (.mclk(mclk), .rst_b(rst_b), .warmReset(warmReset),
		.baud_select_strap(baudStrap), .laterRevision(laterRevision),
		.pllDrivesClock(pllDrivesClock),
		.pll_multiplier_upper_bits(mult), .indexAddr(indexAddr),
		.stackPointer(stackPointer), .flashExecAttempt(flashExecAttempt),
		.memRdReq(memRdReq), .memAddr(memAddr), .memRdData(memRdData),
		.indexAdvance(indexAdvance), .return_from_interrupt(rfiPulse),
		.illegalAddrReset(illegalAddrReset), .flashReadEnable(flashReadEnable),
		.securityBypassed(securityBypassed), .monitorReady(monitorReady),
		.monitor_serial_pin_in(line), .monitor_serial_pin_out(pinOut),
		.monitor_serial_pin_oe(pinOe));

	mhls_host host (.mclk(mclk), .line(line), .pullLow(hostPull));

	////////////////////////////////////////////////////////////////////////////////
	// Memory image: security block holds the key, elsewhere an address hash
	function automatic logic [7:0] mem_val(input logic [15:0] a);
		if (a >= SEC_BASE_ADDR && a <= SEC_BASE_ADDR + 16'h0007)
			return key[3'(a - SEC_BASE_ADDR)];
		return a[7:0] ^ a[15:8];
	endfunction

	// Combinational read: the sequencer takes the data in the request cycle
	assign memRdData = (memRdReq === 1'b1 && flashReadEnable === 1'b1) ?
		mem_val(memAddr) : LOCKED_READ_VALUE;

	// Pulse counters
	always @(posedge mclk)
	begin
		rfiCount += int'(rfiPulse === 1'b1);
		iarCount += int'(illegalAddrReset === 1'b1);
		advCount += int'(indexAdvance === 1'b1);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic wrap_up();
		$display("Counts: %0d checks, %0d mismatches", checksDone, numErrors);
		if (numErrors == 0 && checksDone > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// A frame that never starts ends the run, nothing after it would mean anything
	task automatic expect_frame(input string what, input logic [7:0] exp, input logic stp);
		logic [7:0] r;
		logic       s, ok;
		host.recv_byte(r, s, ok);
		if (ok !== 1'b1)
		begin
			numErrors++;
			$display("mismatch %s expected frame seen none", what);
			wrap_up();
		end
		else
			check(what, {7'h00, s, r}, {7'h00, stp, exp});
	endtask

	task automatic xfer(input logic [7:0] b);
		host.send_byte(b);
		expect_frame("echo", b, 1'b1);
	endtask

	task automatic wait_ready();
		int i;
		for (i = 0; i < 1000 && monitorReady !== 1'b1; i++)
			@(negedge mclk);
		check("ready", {15'h0000, monitorReady}, 16'h0001);
		if (monitorReady !== 1'b1)
			wrap_up();
	endtask

	task automatic power_on();
		@(negedge mclk);
		rst_b = 1'b0;
		repeat (3) @(negedge mclk);
		rst_b = 1'b1;
		repeat (3) @(negedge mclk);
	endtask

	task automatic warm();
		@(negedge mclk);
		warmReset = 1'b1;
		@(negedge mclk);
		warmReset = 1'b0;
		repeat (3) @(negedge mclk);
	endtask

	task automatic exec_try();
		@(negedge mclk);
		flashExecAttempt = 1'b1;
		@(negedge mclk);
		flashExecAttempt = 1'b0;
		repeat (3) @(negedge mclk);
	endtask

	// Bit period picked from strap, revision and PLL while the link is idle
	task automatic check_baud(input logic pll, input logic late, input logic [15:0] exp);
		pllDrivesClock = pll;
		laterRevision  = late;
		@(negedge mclk);
		check("bit period", {5'h00, i_dut.bitPeriod}, exp);
	endtask

	task automatic send_keys(input logic [7:0] mask);
		int i;
		for (i = 0; i < 8; i++)
		begin
			if (i == 7)
				check("early ready", {15'h0000, monitorReady}, 16'h0000);
			xfer(key[i] ^ mask);
		end
		expect_frame("break", 8'h00, 1'b0);
		wait_ready();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_entry_pass();
		power_on();
		check("ready at entry", {15'h0000, monitorReady}, 16'h0000);
		send_keys(8'h00);
		check("bypass", {14'h0000, securityBypassed, flashReadEnable}, 16'h0003);
		$display("test_entry_pass done");
	endtask

	task automatic test_read_sp();
		stackPointer = 16'hA53C;
		xfer(OP_READ_SP);
		expect_frame("sp high", 8'hA5, 1'b1);
		expect_frame("sp low", 8'h3C, 1'b1);
		wait_ready();
		$display("test_read_sp done");
	endtask

	// Index on a page edge so the carry into the high byte is exercised
	task automatic test_indexed_read();
		int a0;
		a0 = advCount;
		indexAddr = 16'h12FF;
		xfer(OP_INDEXED_READ);
		expect_frame("idx first", mem_val(16'h1300), 1'b1);
		expect_frame("idx second", mem_val(16'h1301), 1'b1);
		check("index step", 16'(advCount - a0), 16'h0001);
		wait_ready();
		$display("test_indexed_read done");
	endtask

	// Run at multiplier 3 so the rate scaling is proven on a second value
	task automatic test_run();
		int c0, i;
		mult = 4'h3;
		host.bitPeriod = 1024 / 3;
		c0 = rfiCount;
		xfer(OP_RUN_USER);
		for (i = 0; i < 100 && rfiCount == c0; i++)
			@(negedge mclk);
		check("run pulse", 16'(rfiCount - c0), 16'h0001);
		mult = 4'h6;
		host.bitPeriod = 1024 / 6;
		check_baud(1'b0, 1'b0, 16'h0400);
		check_baud(1'b0, 1'b1, 16'h0450);
		check_baud(1'b1, 1'b0, 16'h00AA);
		$display("test_run done");
	endtask

	task automatic test_warm_keep();
		int i0;
		warm();
		send_keys(8'hFF);
		check("kept", {14'h0000, securityBypassed, flashReadEnable}, 16'h0003);
		i0 = iarCount;
		exec_try();
		check("exec allowed", 16'(iarCount - i0), 16'h0000);
		$display("test_warm_keep done");
	endtask

	task automatic test_fail();
		int i0;
		// Unprogrammed part: the security block reads back as zeros
		key = '{default: 8'h00};
		power_on();
		send_keys(8'hFF);
		check("locked", {14'h0000, securityBypassed, flashReadEnable}, 16'h0000);
		i0 = iarCount;
		exec_try();
		check("exec trap", 16'(iarCount - i0), 16'h0001);
		baudStrap = 1'b0;
		warm();
		check("warm trap", 16'(iarCount - i0), 16'h0002);
		check_baud(1'b0, 1'b0, 16'h0200);
		check_baud(1'b0, 1'b1, 16'h0228);
		check_baud(1'b1, 1'b0, 16'h00AA);
		$display("test_fail done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst_b = 1'b0;
		warmReset = 1'b0;
		flashExecAttempt = 1'b0;
		mult = 4'h6;
		indexAddr = 16'h0000;
		stackPointer = 16'h0000;
		baudStrap = 1'b1;
		laterRevision = 1'b0;
		pllDrivesClock = 1'b1;
		test_entry_pass();
		test_read_sp();
		test_indexed_read();
		test_run();
		test_warm_keep();
		test_fail();
		wrap_up();
	end
endmodule
